//--- design/mpi_pkg.sv
// Constants and types shared by the MII pin interface and management port
package mpi_pkg;

    // ==========================================================
    // Clocking
    // ==========================================================
    localparam int unsigned MGMT_DIV_W     = 8;

    // ==========================================================
    // Widths
    // ==========================================================
    localparam int unsigned NIBBLE_W       = 4;
    localparam int unsigned ADDR_W         = 5;
    localparam int unsigned MGMT_DATA_W    = 16;
    localparam int unsigned MGMT_FRAME_W   = 64;
    localparam int unsigned BIT_CNT_W      = 6;

    // ==========================================================
    // Management frame layout
    // ==========================================================
    localparam logic [31:0] MGMT_PREAMBLE  = 32'hFFFF_FFFF;
    localparam logic [1:0]  MGMT_START     = 2'h1;
    localparam logic [1:0]  MGMT_OP_READ   = 2'h2;
    localparam logic [1:0]  MGMT_OP_WRITE  = 2'h1;
    localparam logic [1:0]  MGMT_TA_WRITE  = 2'h2;
    localparam logic [BIT_CNT_W-1:0] MGMT_LAST_BIT   = 6'h3F;
    localparam logic [BIT_CNT_W-1:0] MGMT_TA_RELEASE = 6'h2F;
    localparam logic [BIT_CNT_W-1:0] MGMT_DATA_FIRST = 6'h30;

    // ==========================================================
    // Synchroniser bit positions
    // ==========================================================
    localparam int unsigned SY_W    = 11;
    localparam int unsigned SY_RXD  = 0;
    localparam int unsigned SY_RXER = 4;
    localparam int unsigned SY_RXDV = 5;
    localparam int unsigned SY_RXCK = 6;
    localparam int unsigned SY_TXCK = 7;
    localparam int unsigned SY_CRS  = 8;
    localparam int unsigned SY_COL  = 9;
    localparam int unsigned SY_MDI  = 10;

    // ==========================================================
    // Reset values
    // ==========================================================
    localparam logic [NIBBLE_W-1:0]    NIBBLE_RST = 4'h0;
    localparam logic [MGMT_DATA_W-1:0] RDATA_RST  = 16'h0000;
    localparam logic [SY_W-1:0]        SYNC_RST   = 11'h000;

    // ==========================================================
    // State types
    // ==========================================================
    typedef enum logic [0:0] {
        TX_IDLE = 1'b0,
        TX_SEND = 1'b1
    } mpi_tx_state_t;

    typedef enum logic [0:0] {
        MG_IDLE = 1'b0,
        MG_RUN  = 1'b1
    } mpi_mgmt_state_t;

endpackage

//--- design/mpi_mgmt_port.sv
// Management data port: clock divider and access frame shifter
`timescale 1ns/10ps
`default_nettype none

module mpi_mgmt_port (
    input  wire logic                              sys_clk_i,
    input  wire logic                              resetn_i,
    input  wire logic [mpi_pkg::MGMT_DIV_W-1:0]   divider_i,
    input  wire logic                              start_i,
    input  wire logic                              read_i,
    input  wire logic [mpi_pkg::ADDR_W-1:0]       phy_addr_i,
    input  wire logic [mpi_pkg::ADDR_W-1:0]       reg_addr_i,
    input  wire logic [mpi_pkg::MGMT_DATA_W-1:0]  wdata_i,
    input  wire logic                              data_sync_i,
    output logic                                   busy_o,
    output logic                                   done_o,
    output logic [mpi_pkg::MGMT_DATA_W-1:0]       rdata_o,
    output logic                                   mgmt_clock_o,
    output logic                                   mgmt_data_o,
    output logic                                   mgmt_data_oe_o
);
    import mpi_pkg::*;

    mpi_mgmt_state_t           state_reg, state_next;
    logic [MGMT_DIV_W-1:0]     div_reg, div_next;
    logic [BIT_CNT_W-1:0]      bit_reg, bit_next;
    logic [MGMT_FRAME_W-1:0]   shift_reg, shift_next;
    logic [MGMT_DATA_W-1:0]    rdata_reg, rdata_next;
    logic                      rd_reg, rd_next;
    logic                      mdc_reg, mdc_next;
    logic                      dout_reg, dout_next;
    logic                      oe_reg, oe_next;
    logic                      busy_reg, busy_next;
    logic                      done_reg, done_next;

    // ==========================================================
    // Frame sequencing
    // ==========================================================
    always_comb begin
        state_next = state_reg;
        div_next   = div_reg;
        bit_next   = bit_reg;
        shift_next = shift_reg;
        rdata_next = rdata_reg;
        rd_next    = rd_reg;
        mdc_next   = mdc_reg;
        dout_next  = dout_reg;
        oe_next    = oe_reg;
        busy_next  = busy_reg;
        done_next  = 1'b0;
        case (state_reg)
            MG_IDLE: begin
                if (start_i) begin
                    shift_next = {MGMT_PREAMBLE, MGMT_START,
                                  read_i ? MGMT_OP_READ : MGMT_OP_WRITE,
                                  phy_addr_i, reg_addr_i, MGMT_TA_WRITE,
                                  read_i ? RDATA_RST : wdata_i}; // [R15] [R19]
                    rd_next    = read_i;
                    bit_next   = '0;
                    div_next   = '0;
                    mdc_next   = 1'b0;
                    dout_next  = MGMT_PREAMBLE[31];
                    oe_next    = 1'b1;                              // [R16]
                    busy_next  = 1'b1;
                    state_next = MG_RUN;
                end
            end
            MG_RUN: begin
                if (div_reg == divider_i) begin                     // [R14]
                    div_next = '0;
                    if (!mdc_reg) begin
                        mdc_next = 1'b1;
                        if (rd_reg && bit_reg >= MGMT_DATA_FIRST) begin
                            rdata_next = {rdata_reg[MGMT_DATA_W-2:0],
                                          data_sync_i};             // [R16]
                        end
                    end else begin
                        mdc_next = 1'b0;
                        if (bit_reg == MGMT_LAST_BIT) begin
                            oe_next    = 1'b0;
                            dout_next  = 1'b1;
                            busy_next  = 1'b0;
                            done_next  = 1'b1;
                            state_next = MG_IDLE;
                        end else begin
                            bit_next   = bit_reg + 1'b1;             // [R15]
                            shift_next = {shift_reg[MGMT_FRAME_W-2:0], 1'b0};
                            dout_next  = shift_reg[MGMT_FRAME_W-2];
                            oe_next    = !(rd_reg &&
                                           bit_next >= MGMT_TA_RELEASE); // [R16]
                        end
                    end
                end else begin
                    div_next = div_reg + 1'b1;
                end
            end
            default: begin
                state_next = MG_IDLE;
            end
        endcase
    end

    always_ff @(posedge sys_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            state_reg <= MG_IDLE;
            div_reg   <= '0;
            bit_reg   <= '0;
            shift_reg <= '0;
            rdata_reg <= RDATA_RST;
            rd_reg    <= 1'b0;
            mdc_reg   <= 1'b0;
            dout_reg  <= 1'b1;
            oe_reg    <= 1'b0;
            busy_reg  <= 1'b0;
            done_reg  <= 1'b0;
        end else begin
            state_reg <= state_next;
            div_reg   <= div_next;
            bit_reg   <= bit_next;
            shift_reg <= shift_next;
            rdata_reg <= rdata_next;
            rd_reg    <= rd_next;
            mdc_reg   <= mdc_next;
            dout_reg  <= dout_next;
            oe_reg    <= oe_next;
            busy_reg  <= busy_next;
            done_reg  <= done_next;
        end
    end

    assign busy_o         = busy_reg;
    assign done_o         = done_reg;
    assign rdata_o        = rdata_reg;
    assign mgmt_clock_o   = mdc_reg;
    assign mgmt_data_o    = dout_reg;
    assign mgmt_data_oe_o = oe_reg;

endmodule // mpi_mgmt_port

`default_nettype wire

//--- design/mpi_mii_top.sv
// MII pin interface of a 10/100 MAC with its management data port
// Notes on behaviour
// R1 - PHY supplies free-running transmit clock; transmit outputs follow it.
// R2 - Transmit error output is held low permanently.
// R3 - Transmit data is a 4-bit nibble, bit 0 least significant.
// R4 - Transmit enable asserted with nibbles, changed on transmit clock.
// R5 - PHY holds collision high while a half-duplex collision lasts.
// R6 - Full duplex: collision blocks new packets; current packet completes.
// R7 - Collision input should be tied low when flow control unused.
// R8 - PHY asserts carrier sense while either direction is busy.
// R9 - Carrier sense should be held low in full duplex.
// R10 - PHY supplies free-running receive clock timing all receive inputs.
// R11 - Receive nibbles captured only while data-valid is asserted.
// R12 - PHY drives data-valid with receive clock while nibbles flow.
// R13 - Receive error honoured only while data-valid is active.
// R14 - Management clock made here by a programmable divider.
// R15 - Access frame sent in order: start, opcode, addresses, data.
// R16 - Management pin driven except read data bits, which are sampled, and the second read turnaround bit.
// R17 - MAC inside talks to an outside PHY through the MII.
// R18 - Collision and carrier sense pass a two-stage synchroniser first.
// R19 - Frame: 32 ones, 01, opcode, 5+5 address, turnaround, 16 data.
`timescale 1ns/10ps
`default_nettype none

module mpi_mii_top (
    input  wire logic                              sys_clk_i,
    input  wire logic                              resetn_i,
    input  wire logic                              duplex_full_i,
    input  wire logic [mpi_pkg::NIBBLE_W-1:0]     tx_data_i,
    input  wire logic                              tx_valid_i,
    input  wire logic                              tx_last_i,
    output logic                                   tx_take_o,
    output logic                                   tx_busy_o,
    output logic [mpi_pkg::NIBBLE_W-1:0]          rx_data_o,
    output logic                                   rx_valid_o,
    output logic                                   rx_error_o,
    output logic                                   rx_end_o,
    output logic                                   collision_o,
    output logic                                   carrier_o,
    input  wire logic                              tx_nibble_clock_i,
    output logic [mpi_pkg::NIBBLE_W-1:0]          tx_nibble_o,
    output logic                                   tx_nibble_enable_o,
    output logic                                   tx_error_out_o,
    input  wire logic                              collision_in_i,
    input  wire logic                              carrier_sense_in_i,
    input  wire logic                              rx_nibble_clock_i,
    input  wire logic [mpi_pkg::NIBBLE_W-1:0]     rx_nibble_i,
    input  wire logic                              rx_nibble_valid_i,
    input  wire logic                              rx_error_in_i,
    input  wire logic [mpi_pkg::MGMT_DIV_W-1:0]   mgmt_clock_divider_i,
    input  wire logic                              mgmt_start_i,
    input  wire logic                              mgmt_read_i,
    input  wire logic [mpi_pkg::ADDR_W-1:0]       mgmt_phy_addr_i,
    input  wire logic [mpi_pkg::ADDR_W-1:0]       mgmt_reg_addr_i,
    input  wire logic [mpi_pkg::MGMT_DATA_W-1:0]  mgmt_wdata_i,
    output logic                                   mgmt_busy_o,
    output logic                                   mgmt_done_o,
    output logic [mpi_pkg::MGMT_DATA_W-1:0]       mgmt_rdata_o,
    output logic                                   mgmt_clock_o,
    output logic                                   mgmt_data_o,
    output logic                                   mgmt_data_oe_o,
    input  wire logic                              mgmt_data_i
);
    import mpi_pkg::*;

    // ==========================================================
    // Pin synchronisers
    // ==========================================================
    logic [SY_W-1:0] sync1_reg, sync1_next;
    logic [SY_W-1:0] sync2_reg, sync2_next;
    logic            txck_prev_reg, txck_prev_next;
    logic            rxck_prev_reg, rxck_prev_next;
    logic            tx_edge;
    logic            rx_fall;

    always_comb begin
        sync1_next = {mgmt_data_i, collision_in_i, carrier_sense_in_i,
                      tx_nibble_clock_i, rx_nibble_clock_i,
                      rx_nibble_valid_i, rx_error_in_i, rx_nibble_i};
        sync2_next     = sync1_reg;                                 // [R18]
        txck_prev_next = sync2_reg[SY_TXCK];
        rxck_prev_next = sync2_reg[SY_RXCK];
    end

    always_ff @(posedge sys_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            sync1_reg     <= SYNC_RST;
            sync2_reg     <= SYNC_RST;
            txck_prev_reg <= 1'b0;
            rxck_prev_reg <= 1'b0;
        end else begin
            sync1_reg     <= sync1_next;
            sync2_reg     <= sync2_next;
            txck_prev_reg <= txck_prev_next;
            rxck_prev_reg <= rxck_prev_next;
        end
    end

    // Rising transmit clock, falling receive clock (mid nibble)
    assign tx_edge = sync2_reg[SY_TXCK] && !txck_prev_reg;          // [R1]
    assign rx_fall = !sync2_reg[SY_RXCK] && rxck_prev_reg;

    assign collision_o = sync2_reg[SY_COL];
    assign carrier_o   = sync2_reg[SY_CRS];

    // ==========================================================
    // Transmit path
    // ==========================================================
    mpi_tx_state_t          tx_state_reg, tx_state_next;
    logic [NIBBLE_W-1:0]    txd_reg, txd_next;
    logic                   txen_reg, txen_next;
    logic                   take_reg, take_next;
    logic                   txer_reg;
    logic                   tx_may_start;

    // Full duplex: collision is flow control; half duplex: defer on carrier
    assign tx_may_start = duplex_full_i ? !sync2_reg[SY_COL]        // [R6]
                                        : !sync2_reg[SY_CRS];

    always_comb begin
        tx_state_next = tx_state_reg;
        txd_next      = txd_reg;
        txen_next     = txen_reg;
        take_next     = 1'b0;
        if (tx_edge) begin                                          // [R4]
            case (tx_state_reg)
                TX_IDLE: begin
                    if (tx_valid_i && tx_may_start) begin           // [R6]
                        txd_next      = tx_data_i;                  // [R3]
                        txen_next     = 1'b1;                       // [R4]
                        take_next     = 1'b1;
                        tx_state_next = tx_last_i ? TX_IDLE : TX_SEND;
                    end else begin
                        txen_next = 1'b0;
                    end
                end
                TX_SEND: begin
                    // A started packet runs on regardless of collision
                    if (tx_valid_i) begin                           // [R6]
                        txd_next      = tx_data_i;                  // [R3]
                        txen_next     = 1'b1;
                        take_next     = 1'b1;
                        tx_state_next = tx_last_i ? TX_IDLE : TX_SEND;
                    end else begin
                        txen_next     = 1'b0;
                        tx_state_next = TX_IDLE;
                    end
                end
                default: begin
                    txen_next     = 1'b0;
                    tx_state_next = TX_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge sys_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            tx_state_reg <= TX_IDLE;
            txd_reg      <= NIBBLE_RST;
            txen_reg     <= 1'b0;
            take_reg     <= 1'b0;
            txer_reg     <= 1'b0;
        end else begin
            tx_state_reg <= tx_state_next;
            txd_reg      <= txd_next;
            txen_reg     <= txen_next;
            take_reg     <= take_next;
            txer_reg     <= 1'b0;                                   // [R2]
        end
    end

    assign tx_nibble_o        = txd_reg;                            // [R17]
    assign tx_nibble_enable_o = txen_reg;
    assign tx_error_out_o     = txer_reg;                           // [R2]
    assign tx_take_o          = take_reg;
    assign tx_busy_o          = txen_reg;

    // ==========================================================
    // Receive path
    // ==========================================================
    logic [NIBBLE_W-1:0] rxd_reg, rxd_next;
    logic                rxv_reg, rxv_next;
    logic                rxe_reg, rxe_next;
    logic                rxend_reg, rxend_next;
    logic                dv_prev_reg, dv_prev_next;

    always_comb begin
        rxd_next     = rxd_reg;
        rxv_next     = 1'b0;
        rxe_next     = 1'b0;
        rxend_next   = 1'b0;
        dv_prev_next = dv_prev_reg;
        if (rx_fall) begin
            dv_prev_next = sync2_reg[SY_RXDV];
            if (sync2_reg[SY_RXDV]) begin                           // [R11]
                rxd_next = sync2_reg[SY_RXD +: NIBBLE_W];           // [R11]
                rxv_next = 1'b1;
                rxe_next = sync2_reg[SY_RXER];                      // [R13]
            end else if (dv_prev_reg) begin
                rxend_next = 1'b1;
            end
        end
    end

    always_ff @(posedge sys_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            rxd_reg     <= NIBBLE_RST;
            rxv_reg     <= 1'b0;
            rxe_reg     <= 1'b0;
            rxend_reg   <= 1'b0;
            dv_prev_reg <= 1'b0;
        end else begin
            rxd_reg     <= rxd_next;
            rxv_reg     <= rxv_next;
            rxe_reg     <= rxe_next;
            rxend_reg   <= rxend_next;
            dv_prev_reg <= dv_prev_next;
        end
    end

    assign rx_data_o  = rxd_reg;
    assign rx_valid_o = rxv_reg;
    assign rx_error_o = rxe_reg;
    assign rx_end_o   = rxend_reg;

    // ==========================================================
    // Management data port
    // ==========================================================
    mpi_mgmt_port u_mgmt (
        .sys_clk_i      (sys_clk_i),
        .resetn_i       (resetn_i),
        .divider_i      (mgmt_clock_divider_i),                     // [R14]
        .start_i        (mgmt_start_i),
        .read_i         (mgmt_read_i),
        .phy_addr_i     (mgmt_phy_addr_i),
        .reg_addr_i     (mgmt_reg_addr_i),
        .wdata_i        (mgmt_wdata_i),
        .data_sync_i    (sync2_reg[SY_MDI]),
        .busy_o         (mgmt_busy_o),
        .done_o         (mgmt_done_o),
        .rdata_o        (mgmt_rdata_o),
        .mgmt_clock_o   (mgmt_clock_o),
        .mgmt_data_o    (mgmt_data_o),
        .mgmt_data_oe_o (mgmt_data_oe_o)
    );

endmodule // mpi_mii_top

`default_nettype wire

//--- dv/mpi_mii_sva.sv
// Assertion checker bound to the MII pin interface top
`timescale 1ns/10ps
`default_nettype none
module mpi_mii_sva (
    input wire logic        sys_clk_i,
    input wire logic        resetn_i,
    input wire logic [3:0]  tx_data_i,
    input wire logic        mgmt_start_i,
    input wire logic        collision_in_i,
    input wire logic        tx_take_o,
    input wire logic        tx_busy_o,
    input wire logic [3:0]  tx_nibble_o,
    input wire logic        tx_nibble_enable_o,
    input wire logic        tx_error_out_o,
    input wire logic [3:0]  rx_data_o,
    input wire logic        rx_valid_o,
    input wire logic        rx_error_o,
    input wire logic        collision_o,
    input wire logic        mgmt_busy_o,
    input wire logic        mgmt_done_o,
    input wire logic        mgmt_clock_o,
    input wire logic        mgmt_data_o,
    input wire logic        mgmt_data_oe_o
);
    default clocking cb @(posedge sys_clk_i); endclocking
    default disable iff (!resetn_i);
    a_txerr_low: assert property (tx_error_out_o == 1'b0)
        else $error("tx error high");
    a_busy_enable: assert property (tx_busy_o == tx_nibble_enable_o)
        else $error("busy not enable");
    a_take_nibble: assert property (tx_take_o |-> tx_nibble_enable_o
        && tx_nibble_o == $past(tx_data_i))
        else $error("nibble not on pins");
    a_enable_rise: assert property ($rose(tx_nibble_enable_o) |-> tx_take_o)
        else $error("enable without take");
    a_rx_error: assert property (rx_error_o |-> rx_valid_o)
        else $error("rx error alone");
    a_rx_hold: assert property (!rx_valid_o |-> $stable(rx_data_o))
        else $error("rx data moved");
    a_col_sync: assert property (collision_o == $past(collision_in_i, 2))
        else $error("collision sync");
    a_mgmt_start: assert property ($rose(mgmt_busy_o) |-> $past(mgmt_start_i)
        && mgmt_data_oe_o && mgmt_data_o && !mgmt_clock_o)
        else $error("bad frame start");
    a_mgmt_done: assert property (mgmt_done_o |-> !mgmt_busy_o
        && $past(mgmt_busy_o) ##1 !mgmt_done_o)
        else $error("bad done pulse");
    a_mgmt_idle: assert property (!mgmt_busy_o |-> !mgmt_clock_o
        && !mgmt_data_oe_o)
        else $error("mgmt pins active idle");
endmodule // mpi_mii_sva
bind mpi_mii_top mpi_mii_sva i_mpi_mii_sva (.*);
`default_nettype wire

//--- dv/mpi_phy_model.sv
// Behavioural model of the external 10/100 transceiver
`timescale 1ns/10ps
`default_nettype none
module mpi_phy_model (
    input  wire logic       mgmt_clock_i,
    input  wire logic       mgmt_data_i,
    input  wire logic       mgmt_oe_i,
    output logic            tx_clk_o,
    output logic            rx_clk_o,
    output logic [3:0]      rx_nibble_o,
    output logic            rx_dv_o,
    output logic            rx_er_o,
    output logic            mdio_o
);
    logic [15:0] rd_val;
    int          cnt = 0;
    initial {tx_clk_o, rx_clk_o, rx_nibble_o, rx_dv_o, rx_er_o, rd_val} = '0;
    always #200 tx_clk_o = ~tx_clk_o;
    initial #137 forever #200 rx_clk_o = ~rx_clk_o;
    task rx_nib(input logic [3:0] d, input logic v, input logic e);
        @(posedge rx_clk_o);
        #5;
        rx_nibble_o = v ? d : ~rx_nibble_o;
        rx_dv_o = v;
        rx_er_o = e;
    endtask
    always @(posedge mgmt_oe_i) cnt = 0;
    always @(negedge mgmt_clock_i) cnt = cnt + 1;
    // Pull-up, then turnaround low and data MSB first
    assign mdio_o = mgmt_oe_i ? mgmt_data_i : (cnt < 47 || cnt > 63) ? 1'b1
                  : (cnt == 47) ? 1'b0 : rd_val[63-cnt];
endmodule // mpi_phy_model
`default_nettype wire

//--- dv/mpi_mii_top_bench.sv
// Self-checking bench for the MII pin interface top
`timescale 1ns/10ps
`default_nettype none
module mpi_mii_top_bench;
    import mpi_pkg::*;
    logic sys_clk_i, resetn_i, duplex_full_i, tx_valid_i, tx_last_i;
    logic collision_in_i, carrier_sense_in_i, mgmt_start_i, mgmt_read_i;
    logic tx_take_o, tx_busy_o, rx_valid_o, rx_error_o, rx_end_o;
    logic collision_o, carrier_o, tx_nibble_enable_o, tx_error_out_o;
    logic mgmt_busy_o, mgmt_done_o, mgmt_clock_o, mgmt_data_o;
    logic mgmt_data_oe_o, mgmt_data_i, tx_nibble_clock_i, rx_nibble_clock_i;
    logic rx_nibble_valid_i, rx_error_in_i;
    logic [3:0]  tx_data_i, rx_data_o, tx_nibble_o, rx_nibble_i, d;
    logic [4:0]  mgmt_phy_addr_i, mgmt_reg_addr_i;
    logic [7:0]  mgmt_clock_divider_i;
    logic [15:0] mgmt_wdata_i, mgmt_rdata_o, last_rd;
    logic [63:0] shf;
    logic [3:0]  txq[$];
    logic [4:0]  rxq[$];
    logic [63:0] mq[$];
    logic [15:0] rq[$];
    int          err_count, n_compared, cyc, n_end;
    mpi_mii_top i_mpi_mii_top (.*);
    mpi_phy_model i_mpi_phy_model (.mgmt_clock_i(mgmt_clock_o),
        .mgmt_data_i(mgmt_data_o), .mgmt_oe_i(mgmt_data_oe_o),
        .tx_clk_o(tx_nibble_clock_i), .rx_clk_o(rx_nibble_clock_i),
        .rx_nibble_o(rx_nibble_i), .rx_dv_o(rx_nibble_valid_i),
        .rx_er_o(rx_error_in_i), .mdio_o(mgmt_data_i));
    // ==========================================================
    // Checking and closing
    task check(input logic [63:0] seen, input logic [63:0] exp);
        n_compared++;
        if (seen !== exp) begin
            err_count++;
            $display("unexpected at %0t: saw %h, wanted %h", $time, seen, exp);
        end
    endtask
    task complete_run;
        $display("compared %0d, mismatches %0d", n_compared, err_count);
        if (err_count == 0 && n_compared > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask
    initial begin
        sys_clk_i = 1'b0;
        forever #50 sys_clk_i = ~sys_clk_i;
    end
    always @(posedge sys_clk_i) begin
        cyc++;
        if (cyc == 20000) begin
            err_count++;
            complete_run;
        end
        if (tx_take_o) check(tx_nibble_o, txq.pop_front());
        if (rx_valid_o) check({rx_error_o, rx_data_o}, rxq.pop_front());
        if (rx_end_o) n_end++;
        if (mgmt_done_o) check(shf, mq.pop_front());
        if (mgmt_done_o) check(mgmt_rdata_o, rq.pop_front());
    end
    always @(posedge mgmt_clock_o) shf = {shf[62:0], mgmt_data_i};
    // ==========================================================
    // Drivers
    task wt(input int n);
        repeat (n) @(posedge sys_clk_i);
        #10;
    endtask
    task tx_packet(input int n);
        int k;
        for (int i = 0; i < n; i++) begin
            tx_data_i = 4'($urandom);
            tx_valid_i = 1'b1;
            tx_last_i = (i == n - 1);
            txq.push_back(tx_data_i);
            k = 0;
            do begin @(posedge sys_clk_i); k++; end
            while (tx_take_o !== 1'b1 && k < 90);
            #10;
        end
        tx_valid_i = 1'b0;
        tx_last_i = 1'b0;
    endtask
    task mgmt_op(input logic rd, input logic [7:0] dv);
        int k;
        logic [15:0] v;
        v = 16'($urandom);
        mgmt_clock_divider_i = dv;
        mgmt_read_i = rd;
        mgmt_phy_addr_i = 5'($urandom);
        mgmt_reg_addr_i = 5'($urandom);
        mgmt_wdata_i = v;
        i_mpi_phy_model.rd_val = v;
        mq.push_back({32'hFFFF_FFFF, 2'b01, rd ? 2'b10 : 2'b01,
                      mgmt_phy_addr_i, mgmt_reg_addr_i, 2'b10, v});
        rq.push_back(rd ? v : last_rd);
        if (rd) last_rd = v;
        mgmt_start_i = 1'b1;
        wt(1);
        k = 0;
        while (mgmt_done_o !== 1'b1 && k < 1200) begin
            mgmt_start_i = (k == 20); // Refused while busy
            wt(1);
            k++;
        end
        mgmt_start_i = 1'b0;
        check(k >= 128 * (dv + 1) - 3 && k <= 128 * (dv + 1) + 3, 1);
    endtask
    // ==========================================================
    // Main sequence
    initial begin
        {resetn_i, duplex_full_i, tx_valid_i, tx_last_i, collision_in_i} = 0;
        {carrier_sense_in_i, mgmt_start_i, mgmt_read_i, tx_data_i} = 0;
        {mgmt_phy_addr_i, mgmt_reg_addr_i, mgmt_wdata_i} = 0;
        mgmt_clock_divider_i = 8'h01;
        {err_count, n_compared, cyc, n_end} = 0;
        last_rd = RDATA_RST;
        void'($urandom(75));
        wt(2);
        resetn_i = 1'b1;
        carrier_sense_in_i = 1'b1;
        for (int i = 0; i < 6; i++) begin
            d = 4'($urandom);
            rxq.push_back({i == 3, d});
            i_mpi_phy_model.rx_nib(d, 1'b1, i == 3);
        end
        i_mpi_phy_model.rx_nib(4'h5, 1'b0, 1'b1);
        i_mpi_phy_model.rx_nib(4'hA, 1'b0, 1'b0);
        check(carrier_o, 1'b1);
        {carrier_sense_in_i, duplex_full_i, collision_in_i} = 3'h3;
        wt(12);
        check(n_end, 1);
        check(rxq.size(), 0);
        fork
            tx_packet(6);
            begin
                wt(40);
                check(tx_busy_o, 1'b0);
                collision_in_i = 1'b0;
                wt(12);
                collision_in_i = 1'b1;
                wt(40);
                collision_in_i = 1'b0;
            end
        join
        wt(10);
        check(tx_nibble_enable_o, 1'b0);
        check(txq.size(), 0);
        mgmt_op(1'b0, 8'h01);
        mgmt_op(1'b1, 8'h03);
        repeat (4) @(posedge sys_clk_i);
        check(mq.size(), 0);
        complete_run;
    end
endmodule // mpi_mii_top_bench
`default_nettype wire
